//--- common/prn_port_pkg.sv
package prn_port_pkg;
   localparam int DATA_W = 8;
   // Printer port register selects on A1:A0
   localparam logic [1:0] SEL_DATA = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   localparam logic [1:0] SEL_CONTROL = 2'h2;
   // Field positions
   localparam int CTL_INIT_BIT = 2;
   localparam int CTL_IRQ_EN_BIT = 4;
   localparam int CTL_DIR_BIT = 5;
   localparam int STS_ERROR_BIT = 3;
   localparam int STS_PAPER_BIT = 5;
   localparam int STS_ACK_BIT = 6;
   // Reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST = 8'h00;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [1:0] addr;
      logic [7:0] wdata;
   } host_bus_t;

   typedef struct packed {
      logic ack_n;
      logic fault_n;
      logic paper_out;
      logic latch_sel;
   } printer_status_t;
endpackage : prn_port_pkg

//--- src/printer_port_host_interface.sv
`timescale 1ns/1ps
// Behaviour
// (RULE1) Fault pin read as general input
// (RULE2) Init pin open-drain, low initializes printer
// (RULE3) Follow mode: irq tracks acknowledge level
// (RULE4) Latched mode: irq holds until read ends
// (RULE5) Irq three-stated until enable bit set
// (RULE6) Latched polarity chosen at build time
// (RULE7) Read places selected register on bus
// (RULE8) Write stores bus into selected register
// (RULE9) Printer data bus bidirectional, latched output
// (RULE10) Paper-out pin read as general input
// (RULE11) Read-active high while host reads
// (RULE12) Reset clears registers and outputs
// (RULE13) Printer pulls acknowledge low after byte
// (RULE14) Host selects port with select low
// (RULE15) Host bus driven only during read
module printer_port_host_interface #(
   parameter bit IRQ_INVERTED = 1'b1
)(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire prn_port_pkg::host_bus_t i_host,
   output logic [prn_port_pkg::DATA_W-1:0] o_host_data,
   output logic o_host_data_oe_n,
   output logic o_read_active_out,
   input wire prn_port_pkg::printer_status_t i_prn,
   input wire logic [prn_port_pkg::DATA_W-1:0] i_printer_data_bus,
   output logic [prn_port_pkg::DATA_W-1:0] o_printer_data_bus,
   output logic o_printer_data_bus_oe_n,
   input wire logic i_printer_init_out,
   output logic o_printer_init_out,
   output logic o_printer_init_out_oe_n,
   output logic o_printer_irq_out,
   output logic o_printer_irq_out_oe_n
);
   import prn_port_pkg::*;

   host_bus_t host_s1, host;
   printer_status_t prn_s1, prn;
   logic [7:0] pd_s1, pd_in;
   logic init_s1, init_in;
   logic [7:0] data_reg;
   logic [7:0] printer_control_reg;
   logic rd_q;
   logic irq_latched;
   logic next_irq_latched;
   logic rd_cycle;
   logic wr_cycle;
   logic rd_end;
   logic [7:0] status_val;
   logic [7:0] read_val;
   logic irq_active;

   // Two-flop synchronisers on every pin input
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         host_s1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 2'h0, wdata: 8'h00};
         host <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 2'h0, wdata: 8'h00};
         prn_s1 <= '{ack_n: 1'b1, fault_n: 1'b1, paper_out: 1'b1, latch_sel: 1'b0};
         prn <= '{ack_n: 1'b1, fault_n: 1'b1, paper_out: 1'b1, latch_sel: 1'b0};
         pd_s1 <= 8'h00;
         pd_in <= 8'h00;
         init_s1 <= 1'b1;
         init_in <= 1'b1;
      end
      else
      begin
         host_s1 <= i_host;
         host <= host_s1;
         prn_s1 <= i_prn;
         prn <= prn_s1;
         pd_s1 <= i_printer_data_bus;
         pd_in <= pd_s1;
         init_s1 <= i_printer_init_out;
         init_in <= init_s1;
      end
   end

   assign rd_cycle = !host.cs_n && !host.rd_n;
   assign wr_cycle = !host.cs_n && !host.wr_n;
   assign rd_end = rd_q && !rd_cycle;

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         rd_q <= 1'b0;
      else
         rd_q <= rd_cycle;
   end

   // Write path
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst) // RULE12
      begin
         data_reg <= DATA_RST;
         printer_control_reg <= CONTROL_RST;
      end
      else if (wr_cycle) // RULE8
      begin
         case (host.addr)
            SEL_DATA: data_reg <= host.wdata; // RULE9
            SEL_CONTROL: printer_control_reg <= host.wdata;
            default: ;
         endcase
      end
   end

   // Status keeps pins raw; software sees the printer's own levels
   always_comb
   begin
      status_val = 8'h00;
      status_val[STS_ERROR_BIT] = prn.fault_n; // RULE1
      status_val[STS_PAPER_BIT] = prn.paper_out; // RULE10
      status_val[STS_ACK_BIT] = prn.ack_n;
   end

   always_comb
   begin
      case (host.addr)
         SEL_DATA: read_val = printer_control_reg[CTL_DIR_BIT] ? pd_in : data_reg;
         SEL_STATUS: read_val = status_val;
         SEL_CONTROL: read_val = {printer_control_reg[7:3], init_in, printer_control_reg[1:0]};
         default: read_val = 8'h00;
      endcase
   end

   // Read data registered so the bus never shows a half-settled mux
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         o_host_data <= 8'h00;
      else if (rd_cycle)
         o_host_data <= read_val; // RULE7
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_host_data_oe_n <= 1'b1;
         o_read_active_out <= 1'b0;
      end
      else
      begin
         o_host_data_oe_n <= !rd_cycle; // RULE15
         o_read_active_out <= rd_cycle; // RULE11
      end
   end

   // Printer data bus; direction bit turns it to input
   assign o_printer_data_bus = data_reg; // RULE9
   assign o_printer_data_bus_oe_n = printer_control_reg[CTL_DIR_BIT];

   // Open drain: drive low only, else release to pull-up
   assign o_printer_init_out = 1'b0;
   assign o_printer_init_out_oe_n = printer_control_reg[CTL_INIT_BIT]; // RULE2

   // Latched interrupt: set on acknowledge, cleared by end of read; set wins
   always_comb
   begin
      next_irq_latched = irq_latched;
      if (rd_end)
         next_irq_latched = 1'b0; // RULE4
      // Only latch in latched mode, so follow-mode acks leave no stale latch
      if (prn.latch_sel && !prn.ack_n)
         next_irq_latched = 1'b1;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         irq_latched <= 1'b0;
      else
         irq_latched <= next_irq_latched;
   end

   assign irq_active = prn.latch_sel ? irq_latched : !prn.ack_n;

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_printer_irq_out <= 1'b0;
         o_printer_irq_out_oe_n <= 1'b1;
      end
      else
      begin
         o_printer_irq_out_oe_n <= !printer_control_reg[CTL_IRQ_EN_BIT]; // RULE5
         if (!prn.latch_sel)
            o_printer_irq_out <= prn.ack_n; // RULE3
         else
            o_printer_irq_out <= irq_active ^ IRQ_INVERTED; // RULE6
      end
   end

   property p_follow;
      @(posedge i_mclk) disable iff (i_sys_rst)
      !prn.latch_sel |=> o_printer_irq_out == $past(prn.ack_n);
   endproperty
   a_irq_follow_ack: assert property (p_follow) else $error("irq not following ack"); // RULE3

   sequence s_ack_latched;
      prn.latch_sel && !prn.ack_n;
   endsequence
   a_irq_latch_set: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE4
      s_ack_latched ##1 prn.latch_sel |=> o_printer_irq_out == !IRQ_INVERTED)
      else $error("latched irq not asserted");

   a_irq_tristate: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE5
      !printer_control_reg[CTL_IRQ_EN_BIT] |=> o_printer_irq_out_oe_n)
      else $error("irq driven while disabled");

   a_read_active: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE11
      rd_cycle |=> o_read_active_out && !o_host_data_oe_n)
      else $error("read not flagged");

   a_bus_release: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE15
      !rd_cycle |=> o_host_data_oe_n)
      else $error("host bus driven outside read");

   a_write_data: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE8
      wr_cycle && host.addr == SEL_DATA |=> o_printer_data_bus == $past(host.wdata))
      else $error("data write lost");

   a_read_data: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE7
      rd_cycle |=> o_host_data == $past(read_val))
      else $error("read data wrong");

   a_reset_state: assert property (@(posedge i_mclk) // RULE12
      i_sys_rst |=> o_printer_irq_out_oe_n && o_host_data_oe_n && !o_read_active_out)
      else $error("outputs not reset");

   a_init_drive: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE2
      wr_cycle && host.addr == SEL_CONTROL |=>
      o_printer_init_out_oe_n == $past(host.wdata[CTL_INIT_BIT]) && !o_printer_init_out)
      else $error("init not driven low");
endmodule : printer_port_host_interface

//--- bench/printer_model.sv
`timescale 1ns/1ps
module printer_model
   import prn_port_pkg::*;
(
   input wire logic [7:0] i_pd_out,
   input wire logic i_pd_oe_n,
   input wire logic i_init_oe_n,
   output printer_status_t o_prn,
   output logic [7:0] o_pd_in,
   output logic o_init_in
);
   initial o_prn = '{1'b1, 1'b1, 1'b0, 1'b0};
   // Printer drives only while the device lets go
   assign o_pd_in = i_pd_oe_n ? 8'hC3 : i_pd_out;
   // Pull-up wins when nobody sinks
   assign o_init_in = i_init_oe_n;
   task automatic set(input logic ack, input logic flt, input logic pe, input logic sel);
      o_prn = '{ack, flt, pe, sel};
   endtask : set
endmodule : printer_model

//--- bench/printer_port_host_interface_tb_top.sv
`timescale 1ns/1ps
module printer_port_host_interface_tb_top;
   import prn_port_pkg::*;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   host_bus_t i_host = '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00};
   printer_status_t prn;
   logic [7:0] hd, pd, pd_in, rd;
   logic hoe_n, ract, pd_oe_n, init_in, init_oe_n, irq, irq_oe_n, irq_pos;
   int err_total = 0;
   int n_compared = 0;
   always #10 i_mclk = ~i_mclk;
   printer_port_host_interface DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_host(i_host),
      .o_host_data(hd), .o_host_data_oe_n(hoe_n), .o_read_active_out(ract), .i_prn(prn),
      .i_printer_data_bus(pd_in), .o_printer_data_bus(pd), .o_printer_data_bus_oe_n(pd_oe_n),
      .i_printer_init_out(init_in), .o_printer_init_out(), .o_printer_init_out_oe_n(init_oe_n),
      .o_printer_irq_out(irq), .o_printer_irq_out_oe_n(irq_oe_n));
   // Non-inverted build, only its interrupt pin is judged
   printer_port_host_interface #(.IRQ_INVERTED(1'b0)) DUT_POS (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_host(i_host), .o_host_data(), .o_host_data_oe_n(), .o_read_active_out(), .i_prn(prn),
      .i_printer_data_bus(pd_in), .o_printer_data_bus(), .o_printer_data_bus_oe_n(),
      .i_printer_init_out(init_in), .o_printer_init_out(), .o_printer_init_out_oe_n(),
      .o_printer_irq_out(irq_pos), .o_printer_irq_out_oe_n());
   printer_model PM (.i_pd_out(pd), .i_pd_oe_n(pd_oe_n), .i_init_oe_n(init_oe_n),
      .o_prn(prn), .o_pd_in(pd_in), .o_init_in(init_in));
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic chk1(input string s, input logic e, input logic g);
      chk(s, {7'h00, e}, {7'h00, g});
   endtask : chk1
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      i_host = '{1'b0, 1'b1, 1'b0, a, d};
      cyc(4);
      i_host = '{1'b1, 1'b1, 1'b1, a, d};
      cyc(4);
   endtask : wr
   task automatic rdr(input logic [1:0] a);
      i_host = '{1'b0, 1'b0, 1'b1, a, 8'h00};
      for (int k = 0; k < 8 && hoe_n !== 1'b0; k++)
         cyc(1);
      chk1("host_oe_n", 1'b0, hoe_n);
      if (hoe_n !== 1'b0)
         complete_run;
      chk1("read_active", 1'b1, ract);
      rd = hd;
      cyc(1);
      i_host = '{1'b1, 1'b1, 1'b1, a, 8'h00};
      cyc(5);
      chk1("host_oe_n", 1'b1, hoe_n);
      chk1("read_active", 1'b0, ract);
   endtask : rdr
   task automatic t_reset;
      chk1("irq_oe_n", 1'b1, irq_oe_n);
      chk("pd", DATA_RST, pd);
      chk1("init_oe_n", 1'b0, init_oe_n);
      rdr(SEL_CONTROL);
      chk("control", CONTROL_RST, rd);
   endtask : t_reset
   task automatic t_data;
      wr(SEL_DATA, 8'hA5);
      wr(SEL_DATA, 8'h5A);
      chk("pd", 8'h5A, pd);
      chk1("pd_oe_n", 1'b0, pd_oe_n);
      rdr(SEL_DATA);
      chk("data", 8'h5A, rd);
      rdr(2'h3);
      chk("unmapped", 8'h00, rd);
      wr(SEL_CONTROL, 8'h24);
      chk1("pd_oe_n", 1'b1, pd_oe_n);
      chk1("init_oe_n", 1'b1, init_oe_n);
      rdr(SEL_CONTROL);
      chk("control", 8'h24, rd);
      rdr(SEL_DATA);
      chk("pd_in", 8'hC3, rd);
      wr(SEL_CONTROL, 8'h00);
   endtask : t_data
   task automatic t_status;
      for (int i = 0; i < 2; i++)
      begin
         PM.set(i[0], i[0], ~i[0], 1'b0);
         cyc(3);
         rdr(SEL_STATUS);
         chk("status", {1'b0, i[0], ~i[0], 1'b0, i[0], 3'h0}, rd & 8'h68);
      end
   endtask : t_status
   task automatic t_irq;
      PM.set(1'b0, 1'b1, 1'b0, 1'b0);
      cyc(4);
      chk1("irq_oe_n", 1'b1, irq_oe_n);
      wr(SEL_CONTROL, 8'h10);
      chk1("irq_oe_n", 1'b0, irq_oe_n);
      chk1("irq", 1'b0, irq);
      PM.set(1'b1, 1'b1, 1'b0, 1'b0);
      cyc(4);
      chk1("irq", 1'b1, irq);
   endtask : t_irq
   task automatic t_latch;
      PM.set(1'b1, 1'b1, 1'b0, 1'b1);
      cyc(4);
      chk1("irq", 1'b1, irq);
      chk1("irq_pos", 1'b0, irq_pos);
      PM.set(1'b0, 1'b1, 1'b0, 1'b1);
      cyc(4);
      PM.set(1'b1, 1'b1, 1'b0, 1'b1);
      cyc(6);
      chk1("irq", 1'b0, irq);
      chk1("irq_pos", 1'b1, irq_pos);
      rdr(SEL_STATUS);
      chk1("irq", 1'b1, irq);
      chk1("irq_pos", 1'b0, irq_pos);
   endtask : t_latch
   task automatic t_midreset;
      wr(SEL_DATA, 8'h3C);
      chk("pd", 8'h3C, pd);
      i_sys_rst = 1'b1;
      cyc(2);
      i_sys_rst = 1'b0;
      cyc(3);
      chk("pd", DATA_RST, pd);
      chk1("irq_oe_n", 1'b1, irq_oe_n);
      chk1("read_active", 1'b0, ract);
   endtask : t_midreset
   initial
   begin
      cyc(2);
      i_sys_rst = 1'b0;
      cyc(3);
      t_reset;
      t_data;
      t_status;
      t_irq;
      t_latch;
      t_midreset;
      complete_run;
   end
endmodule : printer_port_host_interface_tb_top
